/* File: hw/mcu_interrupt_sequencer.sv */
/*
   Interrupt recognition and entry sequencer of an 8-bit controller core:
   edge-latched non-maskable request, level external maskable request,
   prioritised internal maskable request, register stacking and vector load.
   Assumes the core pulses instrDone at each instruction boundary, stalls
   while busy is high, and memory answers a read within one E period.
*/
`timescale 1ns/1ps
`include "irq_seq_defs.svh"

module mcu_interrupt_sequencer
   import irq_seq_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // request pins
   input wire logic nonMaskableRequestN,
   input wire logic external_maskable_request_n,
   // on-chip sources
   input wire logic port3_input_strobe,
   input wire logic port3StrobeEn,
   input wire periph_flags_s periphFlags,
   input wire periph_en_s periphEn,
   // core side
   input wire logic instrDone,
   input wire logic softwareIntReq,
   input wire cpu_regs_s cpuRegs,
   input wire logic [15:0] cpuSp,
   output logic busy,
   output logic maskSet,
   output logic vectorLoad,
   output logic [15:0] newPc,
   output logic [15:0] newSp,
   output logic internal_maskable_request,
   // memory side
   output logic memWe,
   output logic memRe,
   output logic [15:0] memAddr,
   output logic [7:0] memWdata,
   input wire logic [7:0] memRdata,
   // bus clock
   output logic eClk
);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   generate
      if (ADDR_W != 16) begin : g_bad_width
         $error("mcu_interrupt_sequencer supports a 16-bit address only");
      end
   endgenerate

   // ----------------------------------------------------------------
   // E clock divider
   // ----------------------------------------------------------------
   logic [1:0] eCnt_q;
   logic eClk_q;
   wire logic [1:0] eCntD = eCnt_q + 2'h1;
   wire logic eTick = (eCnt_q == `E_LAST);

   // one step of the sequencer per E period
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         eCnt_q <= 2'h0;
         eClk_q <= 1'b0;
      end else begin
         eCnt_q <= eCntD;
         eClk_q <= (eCntD >= `E_HIGH_FROM);
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers and edge latch
   // ----------------------------------------------------------------
   logic nmiS1_q, nmiS2_q, nmiS3_q, extS1_q, extS2_q;
   logic nmiLatch_q;
   wire logic nmiFall = nmiS3_q & ~nmiS2_q;

   // both pins are asynchronous; two flops before any logic
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nmiS1_q <= 1'b1;
         nmiS2_q <= 1'b1;
         nmiS3_q <= 1'b1;
         extS1_q <= 1'b1;
         extS2_q <= 1'b1;
      end else begin
         nmiS1_q <= nonMaskableRequestN;
         nmiS2_q <= nmiS1_q;
         nmiS3_q <= nmiS2_q;
         extS1_q <= external_maskable_request_n;
         extS2_q <= extS1_q;
      end
   end

   // ----------------------------------------------------------------
   // request qualification
   // ----------------------------------------------------------------
   logic internal_maskable_request_q;
   wire logic iMask = cpuRegs.ccr[`CCR_IBIT];
   // serial conditions share a single request
   wire logic serialReq = (periphFlags.receiveFullFlag & periphEn.receiveEn) |
                          (periphFlags.overrunFramingFlag & periphEn.receiveEn) |
                          (periphFlags.transmitEmptyFlag & periphEn.transmitEn);
   wire logic capReq = periphFlags.captureEventFlag & periphEn.captureEn;
   wire logic cmpReq = periphFlags.compareMatchFlag & periphEn.compareEn;
   wire logic ovfReq = periphFlags.counterOverflowFlag & periphEn.overflowEn;
   wire logic irq2D = capReq | cmpReq | ovfReq | serialReq;
   // the external pin and the port 3 strobe feed the external line only
   wire logic extReq = ~extS2_q | (port3_input_strobe & port3StrobeEn);
   wire logic extTake = extReq & ~iMask;
   wire logic intTake = internal_maskable_request_q & ~iMask;
   wire logic anyTake = nmiLatch_q | softwareIntReq | extTake | intTake;

   // fixed priority; external ahead of internal
   wire logic [15:0] intVec = capReq ? `VEC_CAPTURE :
                              cmpReq ? `VEC_COMPARE :
                              ovfReq ? `VEC_OVERFLOW : `VEC_SERIAL;
   wire logic [15:0] vecSel = nmiLatch_q ? `VEC_NMI :
                              softwareIntReq ? `VEC_SWI :
                              extTake ? `VEC_EXT : intVec;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   seq_state_e state_q, state_d;
   logic [2:0] step_q, step_d;
   logic [15:0] vec_q, sp_q, pcHi_q;
   cpu_regs_s regs_q;
   logic busy_q, maskSet_q, vectorLoad_q, memWe_q, memRe_q;
   logic [15:0] newPc_q, newSp_q, memAddr_q;
   logic [7:0] memWdata_q;
   logic [7:0] pushByte [0:6];
   wire logic boundary = (state_q == SEQ_IDLE) & instrDone;
   wire logic enter = boundary & anyTake;
   wire logic [15:0] vecD = enter ? vecSel : vec_q;
   wire logic [15:0] spD = enter ? cpuSp : sp_q;
   wire cpu_regs_s regsD = enter ? cpuRegs : regs_q;
   wire logic [15:0] addrD = (state_d == SEQ_STACK) ? spD - {13'h0, step_d} :
                             (state_d == SEQ_FETCH_HI) ? vecD : (vecD | 16'h0001);

   // stacking order: low PC byte first at the current stack pointer
   assign pushByte[0] = regsD.pc[7:0];
   assign pushByte[1] = regsD.pc[15:8];
   assign pushByte[2] = regsD.x[7:0];
   assign pushByte[3] = regsD.x[15:8];
   assign pushByte[4] = regsD.a;
   assign pushByte[5] = regsD.b;
   assign pushByte[6] = regsD.ccr;

   // next state; memory steps only advance on an E tick
   always_comb begin
      state_d = state_q;
      step_d = step_q;
      case (state_q)
         SEQ_IDLE: begin
            if (enter) begin
               state_d = SEQ_STACK;
               step_d = 3'h0;
            end
         end
         SEQ_STACK: begin
            if (eTick) begin
               if (step_q == `PUSH_LAST) begin
                  state_d = SEQ_FETCH_HI;
               end else begin
                  step_d = step_q + 3'h1;
               end
            end
         end
         SEQ_FETCH_HI: begin
            if (eTick) begin
               state_d = SEQ_FETCH_LO;
            end
         end
         SEQ_FETCH_LO: begin
            if (eTick) begin
               state_d = SEQ_IDLE;
            end
         end
         default: begin
            state_d = SEQ_IDLE;
         end
      endcase
   end

   // sequencer state; reset leaves straight for the reset vector, no stacking
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= SEQ_FETCH_HI;
         step_q <= 3'h0;
         vec_q <= `VEC_RESET;
         sp_q <= 16'h0000;
         regs_q <= '0;
         internal_maskable_request_q <= 1'b0;
      end else begin
         state_q <= state_d;
         step_q <= step_d;
         vec_q <= vecD;
         sp_q <= spD;
         regs_q <= regsD;
         internal_maskable_request_q <= irq2D;
      end
   end

   // latched edge survives a long instruction; a new edge beats the clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nmiLatch_q <= 1'b0;
      end else if (nmiFall) begin
         nmiLatch_q <= 1'b1;
      end else if (enter) begin
         nmiLatch_q <= 1'b0; // cleared whichever source won: nmi wins when set
      end
   end

   // memory port and core handshake outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy_q <= 1'b1;
         memWe_q <= 1'b0;
         memRe_q <= 1'b1;
         memAddr_q <= `VEC_RESET;
         memWdata_q <= 8'h00;
         newSp_q <= 16'h0000;
      end else begin
         busy_q <= (state_d != SEQ_IDLE);
         memWe_q <= (state_d == SEQ_STACK);
         memRe_q <= (state_d == SEQ_FETCH_HI) | (state_d == SEQ_FETCH_LO);
         memAddr_q <= addrD;
         memWdata_q <= pushByte[step_d];
         newSp_q <= enter ? cpuSp - `PUSH_BYTES : newSp_q;
      end
   end

   // mask set as stacking ends, then vector bytes into the new PC
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         maskSet_q <= 1'b0;
         vectorLoad_q <= 1'b0;
         pcHi_q <= 16'h0000;
         newPc_q <= 16'h0000;
      end else begin
         maskSet_q <= (state_q == SEQ_STACK) & (state_d == SEQ_FETCH_HI);
         vectorLoad_q <= (state_q == SEQ_FETCH_LO) & eTick;
         if ((state_q == SEQ_FETCH_HI) & eTick) begin
            pcHi_q <= {memRdata, 8'h00};
         end
         if ((state_q == SEQ_FETCH_LO) & eTick) begin
            newPc_q <= pcHi_q | {8'h00, memRdata};
         end
      end
   end

   assign busy = busy_q;
   assign maskSet = maskSet_q;
   assign vectorLoad = vectorLoad_q;
   assign newPc = newPc_q;
   assign newSp = newSp_q;
   assign internal_maskable_request = internal_maskable_request_q;
   assign memWe = memWe_q;
   assign memRe = memRe_q;
   assign memAddr = memAddr_q;
   assign memWdata = memWdata_q;
   assign eClk = eClk_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   e_divide_a: assert property (@(posedge clk) disable iff (!rstn)
      eTick |=> !eTick [*3] ##1 eTick)
      else $error("E tick not every fourth clock");

   nmi_latch_a: assert property (@(posedge clk) disable iff (!rstn)
      nmiFall |=> nmiLatch_q)
      else $error("falling edge not latched");

   nmi_vector_a: assert property (@(posedge clk) disable iff (!rstn)
      boundary && nmiLatch_q |=> vec_q == `VEC_NMI && state_q == SEQ_STACK)
      else $error("latched edge not served at the boundary");

   mask_gate_a: assert property (@(posedge clk) disable iff (!rstn)
      boundary && iMask && !nmiLatch_q && !softwareIntReq |=> state_q == SEQ_IDLE)
      else $error("masked request entered");

   ext_first_a: assert property (@(posedge clk) disable iff (!rstn)
      enter && extTake && intTake && !nmiLatch_q && !softwareIntReq |=> vec_q == `VEC_EXT)
      else $error("internal request served before external");

   internal_maskable_request_line_a: assert property (@(posedge clk) disable iff (!rstn)
      (capReq || cmpReq) |=> internal_maskable_request)
      else $error("internal line missed a timer event");

   stack_count_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(maskSet_q) |-> $past(step_q) == `PUSH_LAST && $past(memWe_q))
      else $error("stacking ended early");

   vector_load_a: assert property (@(posedge clk) disable iff (!rstn)
      maskSet_q |-> ##[1:12] vectorLoad_q)
      else $error("vector not loaded after mask set");

endmodule // mcu_interrupt_sequencer

/* File: hw/irq_seq_defs.svh */
/*
   Constants of the interrupt sequencer: vector addresses, condition code
   bit position, clock divide and stacking counts.
   Assumes a 16-bit address space and an 8-bit data path.
*/
`ifndef IRQ_SEQ_DEFS_SVH
`define IRQ_SEQ_DEFS_SVH

// ----------------------------------------------------------------
// vector pair high-byte addresses
// ----------------------------------------------------------------
`define VEC_RESET 16'hfffe
`define VEC_NMI 16'hfffc
`define VEC_SWI 16'hfffa
`define VEC_EXT 16'hfff8
`define VEC_CAPTURE 16'hfff6
`define VEC_COMPARE 16'hfff4
`define VEC_OVERFLOW 16'hfff2
`define VEC_SERIAL 16'hfff0

// ----------------------------------------------------------------
// condition code and timing
// ----------------------------------------------------------------
`define CCR_IBIT 4
`define E_LAST 2'h3
`define E_HIGH_FROM 2'h2
`define PUSH_LAST 3'h6
`define PUSH_BYTES 16'h0007

`endif

/* File: hw/irq_seq_pkg.sv */
/*
   Types of the interrupt sequencer: saved register set, peripheral flags,
   enables and sequencer states.
   Assumes the constants header is included by the design module.
*/
package irq_seq_pkg;

   // registers stacked on interrupt entry
   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] x;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] ccr;
   } cpu_regs_s;

   // timer and serial event flags
   typedef struct packed {
      logic captureEventFlag;
      logic compareMatchFlag;
      logic counterOverflowFlag;
      logic receiveFullFlag;
      logic overrunFramingFlag;
      logic transmitEmptyFlag;
   } periph_flags_s;

   // per-source enables
   typedef struct packed {
      logic captureEn;
      logic compareEn;
      logic overflowEn;
      logic receiveEn;
      logic transmitEn;
   } periph_en_s;

   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_STACK,
      SEQ_FETCH_HI,
      SEQ_FETCH_LO
   } seq_state_e;

endpackage

/* File: tb/irq_mem_model.sv */
/*
   Far-side model: memory that serves vector bytes and keeps pushed bytes,
   and an edge source that pulls the non-maskable pin low for a while.
   Assumes the sequencer's memory strobes are registered on clk.
*/
`timescale 1ns/1ps
module irq_mem_model (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // request pin side
   input wire logic fire,
   output logic nmiN,
   // memory side
   input wire logic memRe,
   input wire logic memWe,
   input wire logic [15:0] memAddr,
   input wire logic [7:0] memWdata,
   output logic [7:0] memRdata
);
   logic [2:0] pulseCnt_q;
   logic [7:0] last_q;
   logic [7:0] store [8];

   // read data follows the address; an idle bus shows the inverse of the last byte
   assign memRdata = memRe ? (memAddr[7:0] ^ 8'h3c) : ~last_q;
   // pin has a pull-up, so it idles high
   assign nmiN = (pulseCnt_q == 3'h0);

   // low for six clocks, longer than one E period
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pulseCnt_q <= 3'h0;
         last_q <= 8'h00;
      end else begin
         if (fire) pulseCnt_q <= 3'h6;
         else if (pulseCnt_q != 3'h0) pulseCnt_q <= pulseCnt_q - 3'h1;
         if (memRe) last_q <= memRdata;
      end
   end

   // low address bits suffice: seven pushes never wrap onto each other
   always_ff @(posedge clk) begin
      if (memWe) store[memAddr[2:0]] <= memWdata;
   end
endmodule // irq_mem_model

/* File: tb/tb.sv */
/*
   Self-checking bench of the interrupt sequencer: entries of every kind,
   masking, priority of random flag sets, stacked bytes and E output.
   Assumes the memory model answers vector reads at once.
*/
`timescale 1ns/1ps
`include "irq_seq_defs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
   $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb
   import irq_seq_pkg::*;
;
   logic clk = 0, rstn = 0, fire = 0, extN = 1, strobe = 0, strobeEn = 0, instrDone = 0, swi = 0;
   periph_flags_s flags = '0;
   periph_en_s en = '0;
   cpu_regs_s regs = '0;
   logic [15:0] sp = 16'h0240;
   logic busy, maskSet, vectorLoad, intReq, memWe, memRe, eClk, nmiN;
   logic [15:0] newPc, newSp, memAddr;
   logic [7:0] memWdata, memRdata;
   int errors = 0, checks_done = 0;
   logic [31:0] seed = 32'd99357;

   always #10 clk = ~clk;

   mcu_interrupt_sequencer i_mcu_interrupt_sequencer (.clk(clk), .rstn(rstn),
      .nonMaskableRequestN(nmiN), .external_maskable_request_n(extN),
      .port3_input_strobe(strobe), .port3StrobeEn(strobeEn), .periphFlags(flags), .periphEn(en),
      .instrDone(instrDone), .softwareIntReq(swi), .cpuRegs(regs), .cpuSp(sp), .busy(busy),
      .maskSet(maskSet), .vectorLoad(vectorLoad), .newPc(newPc), .newSp(newSp),
      .internal_maskable_request(intReq), .memWe(memWe), .memRe(memRe), .memAddr(memAddr),
      .memWdata(memWdata), .memRdata(memRdata), .eClk(eClk));
   irq_mem_model i_irq_mem_model (.clk(clk), .rstn(rstn), .fire(fire), .nmiN(nmiN), .memRe(memRe),
      .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));

   // ----------------------------------------
   // expectations
   // ----------------------------------------
   function automatic logic [31:0] nextRand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [15:0] vec(input logic [15:0] a);
      return {a[7:0] ^ 8'h3c, (a[7:0] | 8'h01) ^ 8'h3c};
   endfunction

   // serial conditions merge; timer events rank capture, compare, overflow
   function automatic logic [15:0] expVec(input periph_flags_s f, input periph_en_s e, input logic ext);
      if (ext) return `VEC_EXT;
      if (f.captureEventFlag & e.captureEn) return `VEC_CAPTURE;
      if (f.compareMatchFlag & e.compareEn) return `VEC_COMPARE;
      if (f.counterOverflowFlag & e.overflowEn) return `VEC_OVERFLOW;
      if (((f.receiveFullFlag | f.overrunFramingFlag) & e.receiveEn) | (f.transmitEmptyFlag & e.transmitEn))
         return `VEC_SERIAL;
      return 16'h0000;
   endfunction

   // ----------------------------------------
   // drivers
   // ----------------------------------------
   task automatic setRegs(input logic m);
      logic [63:0] w;
      cpu_regs_s r;
      w = {nextRand(), nextRand()};
      r = w[55:0];
      r.ccr[4] = m;
      @(posedge clk);
      regs <= r;
      sp <= 16'h0200 + {8'h00, w[63:56]};
   endtask

   task automatic pulseDone();
      @(posedge clk) instrDone <= 1'b1;
      @(posedge clk) instrDone <= 1'b0;
   endtask

   // reset held three E periods; the reset vector comes in without stacking
   task automatic boot();
      int n;
      n = 0;
      repeat (11) @(posedge clk);
      #1 `CHK(busy, 1'b1)
      @(posedge clk) rstn <= 1'b1;
      #1;
      while (busy !== 1'b0 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK(newPc, vec(`VEC_RESET))
   endtask

   // synchroniser latency passes before the boundary pulse
   task automatic enter(input logic [15:0] v);
      int n;
      logic ms;
      logic [55:0] b;
      logic [15:0] ad;
      n = 0;
      ms = 0;
      repeat (4) @(posedge clk);
      pulseDone();
      #1;
      while (vectorLoad !== 1'b1 && n < 80) begin
         @(posedge clk);
         #1;
         if (maskSet === 1'b1) ms = 1'b1;
         n++;
      end
      `CHK(vectorLoad, 1'b1)
      `CHK(ms, 1'b1)
      `CHK(newPc, vec(v))
      `CHK(newSp, sp - 16'h0007)
      b = {regs.pc[7:0], regs.pc[15:8], regs.x[7:0], regs.x[15:8], regs.a, regs.b, regs.ccr};
      for (int k = 0; k < 7; k++) begin
         ad = sp - 16'(k);
         `CHK(i_irq_mem_model.store[ad[2:0]], b[55 - 8 * k -: 8])
      end
      repeat (2) @(posedge clk);
   endtask

   task automatic conclude();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      int hi, rises;
      logic prev, ext, m;
      logic [31:0] r;
      logic [15:0] v;
      periph_flags_s f;
      periph_en_s e;
      boot();
      hi = 0;
      rises = 0;
      prev = eClk;
      for (int k = 0; k < 16; k++) begin
         @(posedge clk);
         #1;
         if (eClk === 1'b1) hi++;
         if (eClk === 1'b1 && prev === 1'b0) rises++;
         prev = eClk;
      end
      `CHK(hi, 8)
      `CHK(rises, 4)
      // edge gone before the boundary, mask set: still taken
      setRegs(1'b1);
      @(posedge clk) fire <= 1'b1;
      @(posedge clk) fire <= 1'b0;
      repeat (12) @(posedge clk);
      enter(`VEC_NMI);
      setRegs(1'b0);
      @(posedge clk) swi <= 1'b1;
      enter(`VEC_SWI);
      @(posedge clk) swi <= 1'b0;
      // a masked level request must wait, then be served
      setRegs(1'b1);
      @(posedge clk) extN <= 1'b0;
      repeat (4) @(posedge clk);
      pulseDone();
      repeat (3) @(posedge clk);
      #1 `CHK(busy, 1'b0)
      setRegs(1'b0);
      enter(`VEC_EXT);
      @(posedge clk) extN <= 1'b1;
      @(posedge clk) begin
         strobeEn <= 1'b1;
         strobe <= 1'b1;
      end
      enter(`VEC_EXT);
      @(posedge clk) strobe <= 1'b0;
      // random flag sets; first two passes have every source up, with and without the pin
      for (int i = 0; i < 24; i++) begin
         r = nextRand();
         f = (i < 2) ? '1 : r[5:0];
         e = (i < 2) ? '1 : r[10:6];
         ext = (i == 0) || (i > 1 && r[31:29] == 3'h0);
         m = (i > 1) && r[28] && r[27];
         setRegs(m);
         @(posedge clk) begin
            flags <= f;
            en <= e;
            extN <= !ext;
         end
         repeat (4) @(posedge clk);
         #1 `CHK(intReq, expVec(f, e, 1'b0) != 16'h0000)
         v = m ? 16'h0000 : expVec(f, e, ext);
         if (v == 16'h0000) begin
            pulseDone();
            repeat (3) @(posedge clk);
            #1 `CHK(busy, 1'b0)
         end else enter(v);
      end
      // mid-run reset, then one entry to show the sequencer came back clean
      @(posedge clk) rstn <= 1'b0;
      boot();
      setRegs(1'b0);
      @(posedge clk) swi <= 1'b1;
      enter(`VEC_SWI);
      @(posedge clk) swi <= 1'b0;
      conclude();
   end

   // watchdog, far beyond the expected run length
   initial begin
      #200000;
      errors++;
      conclude();
   end
endmodule // tb
